// File: hw/dims_cmd_if.sv
// Command hand-over between the link-clock decoder and the core logic
`timescale 1ns/1ps
`default_nettype none
interface dims_cmd_if;
    import dims_pkg::*;
    logic                  cmd_toggle;   // Flips once per decoded command
    dims_cmd_t             cmd_kind;
    logic [BA_W-1:0]       cmd_ba;
    logic [ADDR_W-1:0]     cmd_addr;
    logic                  cke_reg;      // Clock enable as registered on the link clock

    modport link (output cmd_toggle, output cmd_kind, output cmd_ba, output cmd_addr, output cke_reg);
    modport core (input cmd_toggle, input cmd_kind, input cmd_ba, input cmd_addr, input cke_reg);
endinterface : dims_cmd_if
`default_nettype wire

// File: hw/dims_init_core.sv
// Memory-side power-up, reset and mode register sequencing
// Overview of operation
// RQ1 - Controller holds reset pin low at least 200us after power is stable.
// RQ2 - Controller drives clock enable low at least 10ns before reset release.
// RQ3 - After reset release the memory self-initializes 500us without the external clock.
// RQ4 - Controller runs a stable clock and a no-op before raising clock enable.
// RQ5 - Clock enable stays high continuously until initialization completes.
// RQ6 - Termination stays high impedance in reset and until clock enable is registered.
// RQ7 - Termination pin stays static from clock enable high until initialization ends.
// RQ8 - First mode load waits the reset exit time after clock enable high.
// RQ9 - Mode loads go in order two, three, one, zero by bank address.
// RQ10 - Register one load enables the DLL; register zero load requests DLL reset.
// RQ11 - Long calibration follows mode loads; then wait DLL lock and calibration time.
// RQ12 - Only no-op or deselect between the mode loads and long calibration.
// RQ13 - Reset at stable power lasts 100ns, then the power-up steps repeat.
// RQ14 - Four mode registers have undefined defaults and must all be written.
// RQ15 - Every mode load drives all address fields of its register.
// RQ16 - Mode loads and DLL reset leave the memory array untouched.
// RQ17 - Consecutive mode loads are separated by the mode-to-mode gap.
// RQ18 - After a mode load only no-ops until the mode-to-other gap passes.
// RQ19 - In normal operation mode loads happen only while the memory is idle.
// RQ20 - Base mode register is selected with all bank address bits low.
// RQ21 - Reserved mode register bits are written as zero.
// RQ22 - Programmed write recovery covers write recovery time in whole clocks.
// RQ23 - DLL reset bit clears itself once the DLL reset has been carried out.
// RQ24 - After DLL reset wait the DLL lock time before reads or termination.
// RQ25 - Wait counts derive from the clock period, rounded up to whole cycles.
`timescale 1ns/1ps
`default_nettype none
module dims_init_core
    import dims_pkg::*;
#(
    parameter int SELF_INIT_CYCLES  = SELF_INIT_CYC,
    parameter int RESET_EXIT_CYCLES = RESET_EXIT_CYC,
    parameter int DLL_LOCK_CYCLES   = DLL_LOCK_CYC,
    parameter int INIT_CAL_CYCLES   = INIT_CAL_CYC
) (
    // Core clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Link clock and reset pin
    input  wire logic              mem_ck,
    input  wire logic              mem_reset_n,
    // Command pins
    input  wire logic              cke,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [BA_W-1:0]   ba,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              term_enable_pin,
    // Mode register read-back
    input  wire logic [1:0]        mode_sel,
    output logic      [MR_W-1:0]   mode_value,
    // Status
    output logic                   term_hiz,
    output logic                   term_active,
    output logic                   self_init_busy,
    output logic [MR_NUM-1:0]      regs_written,
    output logic                   dll_reset_pending,
    output logic                   dll_locked,
    output logic                   cal_done,
    output logic                   ready,
    output logic                   seq_error
);
    typedef enum logic [2:0] {
        ST_IN_RESET,
        ST_SELF_INIT,
        ST_WAIT_CKE,
        ST_CONFIG,
        ST_CALIB,
        ST_READY
    } dims_state_t;

    dims_state_t state;
    dims_state_t next_state;

    dims_cmd_if cmd ();

    logic [1:0]  rst_sync;
    logic [1:0]  cke_sync;
    logic [2:0]  tog_sync;
    logic        pin_rst;
    logic        cke_hi;
    logic        cmd_evt;
    logic        mode_evt;
    logic        zq_evt;
    logic [1:0]  mode_idx;
    logic [19:0] init_cnt;
    logic [19:0] xpr_cnt;
    logic [19:0] dll_cnt;
    logic [19:0] cal_cnt;
    logic        dll_running;
    logic        cal_running;
    logic        dll_done;
    logic        cal_fin;
    logic [1:0]  expect_idx;
    logic        cfg_done;
    logic        order_bad;
    logic        term_pin_q;
    logic        term_pin_s;

    // Map a bank address onto a mode register index
    function automatic logic [1:0] mode_index(input logic [BA_W-1:0] b);
        return b[1:0];
    endfunction : mode_index

    // Expected register after the given one in the power-up order
    function automatic logic [1:0] next_in_order(input logic [1:0] idx);
        unique case (idx)
            BA_EXT_TWO[1:0]:   return BA_EXT_THREE[1:0];
            BA_EXT_THREE[1:0]: return BA_EXT_ONE[1:0];
            BA_EXT_ONE[1:0]:   return BA_BASE_MODE[1:0];
            BA_BASE_MODE[1:0]: return BA_EXT_TWO[1:0];
        endcase
    endfunction : next_in_order

    // Link-clock decoder
    dims_link_cmd u_link (
        .mem_ck      (mem_ck),
        .mem_reset_n (mem_reset_n),
        .cke         (cke),
        .cs_n        (cs_n),
        .ras_n       (ras_n),
        .cas_n       (cas_n),
        .we_n        (we_n),
        .ba          (ba),
        .addr        (addr),
        .cmd         (cmd.link)
    );

    // Synchronisers for reset pin, registered clock enable, command toggle and termination pin
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rst_sync   <= 2'h0;
            cke_sync   <= 2'h0;
            tog_sync   <= 3'h0;
            term_pin_q <= 1'b0;
            term_pin_s <= 1'b0;
        end else begin
            rst_sync   <= {rst_sync[0], mem_reset_n};
            cke_sync   <= {cke_sync[0], cmd.cke_reg};
            tog_sync   <= {tog_sync[1:0], cmd.cmd_toggle};
            term_pin_q <= term_enable_pin;
            term_pin_s <= term_pin_q;
        end
    end

    assign pin_rst  = !rst_sync[1];
    assign cke_hi   = cke_sync[1];
    assign cmd_evt  = tog_sync[2] != tog_sync[1];
    assign mode_evt = cmd_evt && cmd.cmd_kind == DIMS_CMD_MODE;
    assign zq_evt   = cmd_evt && cmd.cmd_kind == DIMS_CMD_ZQ;
    assign mode_idx = mode_index(cmd.cmd_ba);
    assign cfg_done = &regs_written;
    assign dll_done = dll_running && dll_cnt == 20'(DLL_LOCK_CYCLES - 1);
    assign cal_fin  = cal_running && cal_cnt == 20'(INIT_CAL_CYCLES - 1);

    // Sequence state; a reset pin at any point restarts the power-up steps
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= ST_IN_RESET;
        end else if (pin_rst) begin
            state <= ST_IN_RESET; // RQ13
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IN_RESET:  next_state = ST_SELF_INIT;
            ST_SELF_INIT: if (init_cnt == 20'(SELF_INIT_CYCLES - 1)) next_state = ST_WAIT_CKE; // RQ3
            ST_WAIT_CKE:  if (cke_hi) next_state = ST_CONFIG;
            ST_CONFIG:    if (zq_evt) next_state = ST_CALIB; // RQ11
            ST_CALIB:     if (dll_locked && cal_done) next_state = ST_READY; // RQ11
            ST_READY:     next_state = ST_READY;
        endcase
    end

    // Internal initialization timer, runs on the core clock only
    always_ff @(posedge clk) begin
        if (!resetn || state != ST_SELF_INIT) begin
            init_cnt <= 20'h0;
        end else begin
            init_cnt <= init_cnt + 20'h1; // RQ3 RQ25
        end
    end

    // Reset exit timer counted from clock enable seen high
    always_ff @(posedge clk) begin
        if (!resetn || state != ST_CONFIG) begin
            xpr_cnt <= 20'h0;
        end else if (xpr_cnt != 20'(RESET_EXIT_CYCLES)) begin
            xpr_cnt <= xpr_cnt + 20'h1; // RQ8
        end
    end

    // Termination held off until clock enable is registered high
    always_ff @(posedge clk) begin
        if (!resetn) begin
            term_hiz    <= 1'b1;
            term_active <= 1'b0;
        end else if (state == ST_IN_RESET || state == ST_SELF_INIT || state == ST_WAIT_CKE) begin
            term_hiz    <= 1'b1; // RQ6
            term_active <= 1'b0;
        end else begin
            term_hiz    <= 1'b0;
            term_active <= term_pin_s;
        end
    end

    assign self_init_busy = state == ST_IN_RESET || state == ST_SELF_INIT;
    assign ready          = state == ST_READY;

    // Track which mode registers have been written since the last reset
    always_ff @(posedge clk) begin
        if (!resetn || pin_rst) begin
            regs_written <= '0; // RQ14
        end else if (mode_evt && state != ST_SELF_INIT && state != ST_IN_RESET) begin
            regs_written[mode_idx] <= 1'b1;
        end
    end

    // Order expected during power-up configuration
    always_ff @(posedge clk) begin
        if (!resetn || state != ST_CONFIG) begin
            expect_idx <= BA_EXT_TWO[1:0];
        end else if (mode_evt) begin
            expect_idx <= next_in_order(mode_idx); // RQ9
        end
    end

    // Detect a command or clock enable drop that breaks the power-up order, or a mode load missing its required bits
    always_comb begin
        order_bad = 1'b0;
        if (mode_evt && state == ST_CONFIG) begin
            if (cmd.cmd_ba[BA_W-1] || mode_idx != expect_idx) order_bad = 1'b1; // RQ9 RQ20
            if (xpr_cnt != 20'(RESET_EXIT_CYCLES)) order_bad = 1'b1; // RQ8
            if (mode_idx == BA_EXT_ONE[1:0] && cmd.cmd_addr[DLL_DISABLE_BIT]) order_bad = 1'b1; // RQ10
            if (mode_idx == BA_BASE_MODE[1:0] && !cmd.cmd_addr[DLL_RESET_BIT]) order_bad = 1'b1; // RQ10
        end
        if (zq_evt && state == ST_CONFIG && !cfg_done) order_bad = 1'b1; // RQ14
        if (cmd_evt && state == ST_CALIB) order_bad = 1'b1; // RQ11
        if ((state == ST_CONFIG || state == ST_CALIB) && !cke_hi) order_bad = 1'b1; // RQ5
    end

    // Sticky sequence error, cleared only by a reset
    always_ff @(posedge clk) begin
        if (!resetn || pin_rst) begin
            seq_error <= 1'b0;
        end else if (order_bad) begin
            seq_error <= 1'b1;
        end
    end

    // DLL lock timer started by a base register load with DLL reset requested
    always_ff @(posedge clk) begin
        if (!resetn || pin_rst) begin
            dll_running <= 1'b0;
            dll_cnt     <= 20'h0;
            dll_locked  <= 1'b0;
        end else if (mode_evt && mode_idx == BA_BASE_MODE[1:0] && cmd.cmd_addr[DLL_RESET_BIT]) begin
            dll_running <= 1'b1; // RQ24
            dll_cnt     <= 20'h0;
            dll_locked  <= 1'b0;
        end else if (dll_done) begin
            dll_running <= 1'b0;
            dll_locked  <= 1'b1; // RQ24
        end else if (dll_running) begin
            dll_cnt <= dll_cnt + 20'h1;
        end
    end

    assign dll_reset_pending = dll_running;

    // Initial calibration timer started by the long calibration command
    always_ff @(posedge clk) begin
        if (!resetn || pin_rst) begin
            cal_running <= 1'b0;
            cal_cnt     <= 20'h0;
            cal_done    <= 1'b0;
        end else if (zq_evt) begin
            cal_running <= 1'b1; // RQ11
            cal_cnt     <= 20'h0;
            cal_done    <= 1'b0;
        end else if (cal_fin) begin
            cal_running <= 1'b0;
            cal_done    <= 1'b1;
        end else if (cal_running) begin
            cal_cnt <= cal_cnt + 20'h1;
        end
    end

    // Mode register storage; only register contents change, never the array
    dims_mode_mem #(
        .WIDTH (MR_W),
        .DEPTH (MR_NUM)
    ) u_mem (
        .clk      (clk),
        .resetn   (resetn && !pin_rst), // RQ14
        .wr_en    (mode_evt && !self_init_busy), // RQ15 RQ16
        .wr_addr  (mode_idx),
        .wr_data  (MR_W'(cmd.cmd_addr)),
        .clr_en   (dll_done), // RQ23
        .clr_addr (BA_BASE_MODE[1:0]),
        .clr_mask (MR_W'(1) << DLL_RESET_BIT),
        .rd_addr  (mode_sel),
        .rd_data  (mode_value)
    );
endmodule : dims_init_core
`default_nettype wire

// File: hw/dims_link_cmd.sv
// Link-clock command decoder: registers pins on the memory clock and hands commands over
`timescale 1ns/1ps
`default_nettype none
module dims_link_cmd
    import dims_pkg::*;
(
    // Link clock and reset pin
    input  wire logic              mem_ck,
    input  wire logic              mem_reset_n,
    // Command pins
    input  wire logic              cke,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [BA_W-1:0]   ba,
    input  wire logic [ADDR_W-1:0] addr,
    // To the core
    dims_cmd_if.link               cmd
);
    logic cke_prev;
    logic is_mode;
    logic is_zq;

    // Decode only while clock enable is high in this and the previous cycle
    assign is_mode = cke_prev && cke && !cs_n && !ras_n && !cas_n && !we_n;
    assign is_zq   = cke_prev && cke && !cs_n && ras_n && cas_n && !we_n && addr[ZQ_LONG_BIT];

    // Clock enable register; the reset pin clears it with no clock running
    always_ff @(posedge mem_ck or negedge mem_reset_n) begin
        if (!mem_reset_n) begin
            cke_prev    <= 1'b0;
            cmd.cke_reg <= 1'b0;
        end else begin
            cke_prev    <= cke;
            cmd.cke_reg <= cke;
        end
    end

    // Capture command word and flip the toggle; word stays put until the next command
    always_ff @(posedge mem_ck or negedge mem_reset_n) begin
        if (!mem_reset_n) begin
            cmd.cmd_toggle <= 1'b0;
            cmd.cmd_kind   <= DIMS_CMD_MODE;
            cmd.cmd_ba     <= '0;
            cmd.cmd_addr   <= '0;
        end else if (is_mode || is_zq) begin
            cmd.cmd_toggle <= !cmd.cmd_toggle;
            cmd.cmd_kind   <= is_mode ? DIMS_CMD_MODE : DIMS_CMD_ZQ;
            cmd.cmd_ba     <= ba;
            cmd.cmd_addr   <= addr;
        end
    end
endmodule : dims_link_cmd
`default_nettype wire

// File: hw/dims_mode_mem.sv
// Storage for the four mode registers with a registered read port
`timescale 1ns/1ps
`default_nettype none
module dims_mode_mem
    import dims_pkg::*;
#(
    parameter int WIDTH = MR_W,
    parameter int DEPTH = MR_NUM
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // Full-word write
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    // Bit clear, used for self-clearing fields
    input  wire logic                     clr_en,
    input  wire logic [$clog2(DEPTH)-1:0] clr_addr,
    input  wire logic [WIDTH-1:0]         clr_mask,
    // Read port
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Writes take priority over a clear of the same word
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= WIDTH'(MR_RESET_VAL);
            end
        end else begin
            if (clr_en && !(wr_en && wr_addr == clr_addr)) begin
                mem[clr_addr] <= mem[clr_addr] & ~clr_mask;
            end
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
        end
    end

    // Registered read data
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : dims_mode_mem
`default_nettype wire

// File: hw/dims_pkg.sv
// Shared constants for the memory initialization and mode register block
package dims_pkg;
    // Widths of the command pins and mode words, and number of mode registers
    localparam int ADDR_W = 15;
    localparam int BA_W   = 3;
    localparam int MR_W   = 16;
    localparam int MR_NUM = 4;

    // Core clock rate and wait times in their own units
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SELF_INIT_US    = 500;
    localparam int SELF_INIT_CYC   = (SELF_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_EXIT_CYC  = 5;
    localparam int DLL_LOCK_CYC    = 512;
    localparam int INIT_CAL_CYC    = 512;

    // Bank-address selection of the four mode registers
    localparam logic [BA_W-1:0] BA_BASE_MODE = 3'h0;
    localparam logic [BA_W-1:0] BA_EXT_ONE   = 3'h1;
    localparam logic [BA_W-1:0] BA_EXT_TWO   = 3'h2;
    localparam logic [BA_W-1:0] BA_EXT_THREE = 3'h3;

    // Field positions inside the mode words and the long calibration command address
    localparam int DLL_DISABLE_BIT = 0;
    localparam int DLL_RESET_BIT   = 8;
    localparam int ZQ_LONG_BIT     = 10;

    // Value of every mode register after reset
    localparam logic [MR_W-1:0] MR_RESET_VAL = 16'h0000;

    // Kind of command handed from the link to the core
    typedef enum logic {
        DIMS_CMD_MODE,
        DIMS_CMD_ZQ
    } dims_cmd_t;
endpackage : dims_pkg

// File: tb/dims_ctl_model.sv
// Controller model driving the memory pins
`timescale 1ns/1ps
`default_nettype none
module dims_ctl_model
    import dims_pkg::*;
#(
    parameter int SELF_NS = 800
) (
    // Link clock and reset pin
    output logic              mem_ck,
    output logic              mem_reset_n,
    // Command pins
    output logic              cke,
    output logic              cs_n,
    output logic              ras_n,
    output logic              cas_n,
    output logic              we_n,
    output logic [BA_W-1:0]   ba,
    output logic [ADDR_W-1:0] addr,
    output logic              term_enable_pin
);
    logic ck_run = 1'b0;

    // Power-up: reset and cke low, deselected
    initial begin
        mem_ck = 1'b0;
        {mem_reset_n, cke, cs_n, ras_n, cas_n, we_n} = 6'h0f;
        ba = '0;
        addr = '0;
        term_enable_pin = 1'b0;
    end

    // Memory clock, stopped during reset
    always #24 mem_ck = ck_run ? ~mem_ck : 1'b0;

    // Reset pulse, clock stopped, cke low
    task automatic pin_reset(input int ns);
        ck_run = 1'b0;
        cke = 1'b0;
        mem_reset_n = 1'b0;
        #(ns);
        mem_reset_n = 1'b1;
    endtask : pin_reset

    // One command, then deselect with lines inverted
    task automatic issue(input logic [2:0] rcw, input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a);
        @(posedge mem_ck);
        {cs_n, ras_n, cas_n, we_n} <= {1'b0, rcw};
        ba <= b;
        addr <= a;
        @(posedge mem_ck);
        {cs_n, ras_n, cas_n, we_n} <= 4'hf;
        ba <= ~b;
        addr <= ~a;
        repeat (4) @(posedge mem_ck);
    endtask : issue

    // Self-init wait, clock and cke start, loads, long calibration
    task automatic init(input logic [1:0] ord[4], input logic [ADDR_W-1:0] val[4]);
        #(SELF_NS);
        ck_run = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        repeat (6) @(posedge mem_ck);
        cke <= 1'b1;
        repeat (4) @(posedge mem_ck);
        for (int i = 0; i < 4; i++) begin
            issue(3'h0, {1'b0, ord[i]}, val[ord[i]]);
        end
        issue(3'h6, '0, 15'h0400);
    endtask : init
endmodule : dims_ctl_model
`default_nettype wire

// File: tb/dims_init_core_chk.sv
// Port checker for the init core
`timescale 1ns/1ps
`default_nettype none
module dims_init_core_chk
    import dims_pkg::*;
#(
    parameter int SELF_INIT_CYCLES = SELF_INIT_CYC,
    parameter int DLL_LOCK_CYCLES  = DLL_LOCK_CYC
) (
    // Clock and resets
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              mem_reset_n,
    // Status
    input wire logic              term_hiz,
    input wire logic              self_init_busy,
    input wire logic [MR_NUM-1:0] regs_written,
    input wire logic              dll_reset_pending,
    input wire logic              dll_locked,
    input wire logic              cal_done,
    input wire logic              ready,
    input wire logic              seq_error
);
    int         busy_cnt;
    int         lock_cnt;
    logic [3:0] pin_hist;
    logic       held;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Busy cycles after pin release
    always_ff @(posedge clk) begin
        if (!resetn || !self_init_busy || !mem_reset_n) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    // Length of the latest lock wait
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lock_cnt <= 0;
        end else if ($rose(dll_reset_pending)) begin
            lock_cnt <= 1;
        end else if (dll_reset_pending) begin
            lock_cnt <= lock_cnt + 1;
        end
    end

    // Held: no pin reset in flight
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_hist <= 4'h0;
        end else begin
            pin_hist <= {pin_hist[2:0], mem_reset_n};
        end
    end
    assign held = (&pin_hist) && mem_reset_n;

    chk_hiz_in_reset: assert property (!mem_reset_n [*4] |=> term_hiz)
        else $error("hiz off in reset");
    chk_hiz_while_busy: assert property (self_init_busy && $past(self_init_busy) |-> term_hiz)
        else $error("hiz off in self init");
    chk_ready_term_on: assert property (ready |-> !term_hiz)
        else $error("hiz on when ready");
    chk_busy_length: assert property ($fell(self_init_busy) |->
        busy_cnt >= SELF_INIT_CYCLES && busy_cnt <= SELF_INIT_CYCLES + 6)
        else $error("self init length");
    chk_lock_wait_len: assert property ($rose(dll_locked) |-> lock_cnt >= DLL_LOCK_CYCLES)
        else $error("lock too early");
    chk_lock_clears_pend: assert property ($rose(dll_locked) |-> !dll_reset_pending)
        else $error("pending after lock");
    chk_ready_all_done: assert property (ready |-> regs_written == 4'hf && dll_locked && cal_done)
        else $error("ready too early");
    chk_busy_no_regs: assert property (self_init_busy && $past(self_init_busy) |-> regs_written == 4'h0)
        else $error("written in reset");
    chk_written_keep: assert property (held |-> (regs_written & $past(regs_written)) == $past(regs_written))
        else $error("written mark lost");
    chk_error_sticky: assert property (held && seq_error |=> seq_error)
        else $error("error dropped");
endmodule : dims_init_core_chk

bind dims_init_core dims_init_core_chk #(.SELF_INIT_CYCLES(SELF_INIT_CYCLES), .DLL_LOCK_CYCLES(DLL_LOCK_CYCLES))
    i_dims_init_core_chk (
    .clk(clk),
    .resetn(resetn),
    .mem_reset_n(mem_reset_n),
    .term_hiz(term_hiz),
    .self_init_busy(self_init_busy),
    .regs_written(regs_written),
    .dll_reset_pending(dll_reset_pending),
    .dll_locked(dll_locked),
    .cal_done(cal_done),
    .ready(ready),
    .seq_error(seq_error)
);
`default_nettype wire

// File: tb/dims_init_core_tb.sv
// Self-checking bench for the init core
`timescale 1ns/1ps
`default_nettype none
module dims_init_core_tb;
    import dims_pkg::*;
    localparam int SI = 50;
    localparam int DL = 20;
    localparam int IC = 20;

    logic              clk = 1'b0;
    logic              resetn;
    logic [1:0]        mode_sel;
    logic [MR_W-1:0]   mode_value;
    logic              term_hiz, term_active, self_init_busy, dll_locked, ready, seq_error;
    logic [MR_NUM-1:0] regs_written;
    logic              mem_ck, mem_reset_n, cke, cs_n, ras_n, cas_n, we_n, term_enable_pin;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] val[4];
    logic [1:0]        ord[4];
    int                mismatches = 0;
    int                n_tests = 0;

    always #5 clk = ~clk;

    dims_init_core #(.SELF_INIT_CYCLES(SI), .RESET_EXIT_CYCLES(RESET_EXIT_CYC),
        .DLL_LOCK_CYCLES(DL), .INIT_CAL_CYCLES(IC)) i_dims_init_core (
        .clk(clk), .resetn(resetn), .mem_ck(mem_ck), .mem_reset_n(mem_reset_n),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
        .addr(addr), .term_enable_pin(term_enable_pin), .mode_sel(mode_sel),
        .mode_value(mode_value), .term_hiz(term_hiz), .term_active(term_active),
        .self_init_busy(self_init_busy), .regs_written(regs_written),
        .dll_reset_pending(), .dll_locked(dll_locked), .cal_done(), .ready(ready),
        .seq_error(seq_error));

    dims_ctl_model #(.SELF_NS(SI * CLK_PERIOD_NS + 300)) i_dims_ctl_model (
        .mem_ck(mem_ck), .mem_reset_n(mem_reset_n), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
        .term_enable_pin(term_enable_pin));

    // Stored load: bit 15 zero, base DLL reset bit self-clears
    function automatic logic [MR_W-1:0] expect_mode(input int idx, input logic [ADDR_W-1:0] v);
        return {1'b0, v} & ~(MR_W'(idx == 0) << DLL_RESET_BIT);
    endfunction : expect_mode

    task automatic chk(input logic [MR_W-1:0] got, input logic [MR_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({15'h0, got}, {15'h0, exp});
    endtask : chk1

    task automatic results();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // Bounded wait for ready
    task automatic wait_ready();
        for (int i = 0; i < 2000; i++) begin
            @(negedge clk);
            if (ready === 1'b1) begin
                return;
            end
        end
        mismatches++;
        results();
    endtask : wait_ready

    // Read back mode registers
    task automatic read_all();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            mode_sel <= 2'(i);
            @(posedge clk);
            @(negedge clk);
            chk(mode_value, expect_mode(i, val[i]));
        end
    endtask : read_all

    // Random values, DLL enabled and reset requested
    task automatic new_vals();
        for (int i = 0; i < 4; i++) begin
            val[i] = ADDR_W'($urandom());
        end
        val[1][DLL_DISABLE_BIT] = 1'b0;
        val[0][DLL_RESET_BIT] = 1'b1;
    endtask : new_vals

    // Power-up, bad-order restart, clean restart
    initial begin
        resetn = 1'b0;
        mode_sel = 2'h0;
        void'($urandom(47));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            new_vals();
            ord = '{2'h2, 2'h3, 2'h1, 2'h0};
            if (r == 1) begin
                ord = '{2'h3, 2'h2, 2'h1, 2'h0};
            end
            i_dims_ctl_model.pin_reset(r == 0 ? 200000 : 100);
            @(negedge clk);
            chk1(self_init_busy, 1'b1);
            chk1(term_hiz, 1'b1);
            chk1(seq_error, 1'b0);
            chk({12'h0, regs_written}, 16'h0000);
            i_dims_ctl_model.init(ord, val);
            if (r == 1) begin
                repeat (10) @(negedge clk);
                chk1(seq_error, 1'b1);
            end else begin
                chk({12'h0, regs_written}, 16'h000f);
                wait_ready();
                chk1(term_hiz, 1'b0);
                chk1(term_active, 1'b0);
                chk1(seq_error, 1'b0);
                chk1(dll_locked, 1'b1);
                read_all();
            end
        end
        val[2] = ADDR_W'($urandom());
        i_dims_ctl_model.issue(3'h0, BA_EXT_TWO, val[2]);
        repeat (8) @(negedge clk);
        read_all();
        chk1(ready, 1'b1);
        results();
    end
endmodule : dims_init_core_tb
`default_nettype wire
